// file: fdn_map.vh
// Register map, field positions, reset values and timing counts of the
// fractional-N divider control block.
// Assumes a 32-bit classic Wishbone slave port with word-aligned registers.
`ifndef FDN_MAP_VH
`define FDN_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define FDN_ADDR_CFG0     8'h00
`define FDN_ADDR_NUM      8'h04
`define FDN_ADDR_DEN      8'h08
`define FDN_ADDR_REF      8'h0C
`define FDN_ADDR_CAL      8'h10
`define FDN_ADDR_STAT     8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define FDN_CFG0_INT      15:0
`define FDN_CFG0_ORDER    17:16
`define FDN_CFG0_DITHER   19:18
`define FDN_FRAC_W        22
`define FDN_REF_RDIV      11:0
`define FDN_REF_DBL       12
`define FDN_REF_ODIV      21:16
`define FDN_CAL_CODE      7:0
`define FDN_CAL_CORE      9:8
`define FDN_CAL_WIN       25:16

// ****************************************************************
// Reset values
// ****************************************************************
`define FDN_RST_INT       16'h0064
`define FDN_RST_DEN       22'h000001
`define FDN_RST_RDIV      12'h001
`define FDN_RST_ODIV      6'h02
`define FDN_RST_CODE      8'h7F
`define FDN_RST_WIN       10'h064
`define FDN_DEN_MAX       22'h3FFFFF
`define FDN_LFSR_SEED     16'hACE1

// ****************************************************************
// Calibration limits
// ****************************************************************
`define FDN_CAL_MAX_STEPS 9'h100

`endif

// file: fdn_mash_acc.v
// One accumulator stage of the cascaded delta-sigma modulator.
// Assumes in_i is below den_i and den_i is at least one.
`default_nettype none

module fdn_mash_acc
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire        clr_i,
  input  wire        step_i,
  input  wire [21:0] den_i,
  input  wire [21:0] in_i,
  output reg  [21:0] acc_o,
  output reg         carry_o
);

  wire [22:0] sum_w = {1'b0, acc_o} + {1'b0, in_i};

  // Wrap modulo the denominator; the carry is the stage's one-bit output
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_o   <= 22'h000000;
      carry_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (clr_i)
      begin
        acc_o   <= 22'h000000;
        carry_o <= 1'b0;
      end
      else if (step_i)
      begin
        if (sum_w >= {1'b0, den_i})
        begin
          acc_o   <= sum_w[21:0] - den_i;
          carry_o <= 1'b1;
        end
        else
        begin
          acc_o   <= sum_w[21:0];
          carry_o <= 1'b0;
        end
      end
    end
  end

endmodule // fdn_mash_acc

`default_nettype wire

// file: fdn_core.v
// Reference path, fractional-N feedback divider, delta-sigma modulator and
// VCO band calibration sequencer, with a classic Wishbone register port.
// Assumes reference and VCO feedback arrive as asynchronous pins that are
// slow against clk_i, so each edge is seen after a two-flop synchroniser.
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`default_nettype none
`include "fdn_map.vh"

module fdn_core
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        reference_input_i,
  input  wire        vco_feedback_i,
  output reg         pd_tick_o,
  output reg         fb_tick_o,
  output reg         out_clk_o,
  output reg  [17:0] n_inst_o,
  output reg  [1:0]  vco_core_o,
  output reg  [7:0]  osc_cap_select_code_o,
  output reg         cal_busy_o
);

  // ****************************************************************
  // Calibration states
  // ****************************************************************
  localparam [2:0] CAL_IDLE = 3'b001;
  localparam [2:0] CAL_MEAS = 3'b010;
  localparam [2:0] CAL_DONE = 3'b100;

  // Byte-lane merge, used by every writable register
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer k;
    begin
      merge = old_v;
      for (k = 0; k < 4; k = k + 1)
        if (sel[k])
          merge[k*8 +: 8] = new_v[k*8 +: 8];
    end
  endfunction

  reg  [31:0] cfg0_q, num_q, den_q, ref_q, cal_q;
  reg  [2:0]  ref_sync_q, vco_sync_q;
  reg  [11:0] rcnt_q;
  reg  [17:0] fcnt_q;
  reg  [5:0]  ocnt_q;
  reg         c2p_q, c3p_q, c3pp_q;
  reg  [15:0] lfsr_q;
  reg  [2:0]  cal_st_q;
  reg  [9:0]  win_q;
  reg  [25:0] vcnt_q;
  reg  [8:0]  steps_q;
  reg         dir_q, dir_ok_q, cal_done_q;

  // ****************************************************************
  // Register port
  // ****************************************************************
  wire        req_w   = wb_cyc_i & wb_stb_i;
  wire        wr_w    = req_w & wb_we_i & wb_ack_o;
  wire        cfg0_wr = wr_w & (wb_adr_i == `FDN_ADDR_CFG0);
  wire [31:0] wmerge  = (wb_adr_i == `FDN_ADDR_NUM) ? merge(num_q, wb_dat_i, wb_sel_i) :
                        merge(den_q, wb_dat_i, wb_sel_i);
  wire [31:0] status_w = {20'h00000, osc_cap_select_code_o, vco_core_o, cal_done_q, cal_busy_o};

  // Ack one cycle after the request; writes land on the edge that samples ack
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      cfg0_q   <= {12'h000, 2'b00, 2'b00, `FDN_RST_INT};
      num_q    <= 32'h00000000;
      den_q    <= {10'h000, `FDN_RST_DEN};
      ref_q    <= {10'h000, `FDN_RST_ODIV, 3'b000, 1'b0, `FDN_RST_RDIV};
      cal_q    <= {6'h00, `FDN_RST_WIN, 6'h00, 2'b00, `FDN_RST_CODE};
    end
    else if (ce_i)
    begin
      wb_ack_o <= req_w & ~wb_ack_o;
      if (req_w & ~wb_ack_o)
      begin
        case (wb_adr_i)
          `FDN_ADDR_CFG0: wb_dat_o <= {12'h000, cfg0_q[19:0]};
          `FDN_ADDR_NUM:  wb_dat_o <= {10'h000, num_q[21:0]};
          `FDN_ADDR_DEN:  wb_dat_o <= {10'h000, den_q[21:0]};
          `FDN_ADDR_REF:  wb_dat_o <= {10'h000, ref_q[21:16], 3'b000, ref_q[12:0]};
          `FDN_ADDR_CAL:  wb_dat_o <= {6'h00, cal_q[25:16], 6'h00, cal_q[9:0]};
          `FDN_ADDR_STAT: wb_dat_o <= status_w;
          default:        wb_dat_o <= 32'h00000000;
        endcase
      end
      if (cfg0_wr)
        cfg0_q <= merge(cfg0_q, wb_dat_i, wb_sel_i);
      if (wr_w & (wb_adr_i == `FDN_ADDR_NUM))
        num_q <= wmerge;
      // A zero denominator is meaningless, so it is held at one
      if (wr_w & (wb_adr_i == `FDN_ADDR_DEN))
        den_q <= (wmerge[21:0] == 22'h000000) ? {10'h000, `FDN_RST_DEN} : {10'h000, wmerge[21:0]};
      if (wr_w & (wb_adr_i == `FDN_ADDR_REF))
        ref_q <= merge(ref_q, wb_dat_i, wb_sel_i);
      if (wr_w & (wb_adr_i == `FDN_ADDR_CAL))
        cal_q <= merge(cal_q, wb_dat_i, wb_sel_i);
    end
  end

  // ****************************************************************
  // Pin synchronisers and edge events
  // ****************************************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_sync_q <= 3'b000;
      vco_sync_q <= 3'b000;
    end
    else if (ce_i)
    begin
      ref_sync_q <= {ref_sync_q[1:0], reference_input_i};
      vco_sync_q <= {vco_sync_q[1:0], vco_feedback_i};
    end
  end

  // Edge detectors look only at the second and third stages
  wire ref_rise = ref_sync_q[1] & ~ref_sync_q[2];
  wire ref_ev   = ref_q[`FDN_REF_DBL] ? (ref_sync_q[1] ^ ref_sync_q[2]) : ref_rise;
  wire vco_ev   = vco_sync_q[1] & ~vco_sync_q[2];

  // ****************************************************************
  // Reference doubler and R divider
  // ****************************************************************
  wire [11:0] rdiv_w = (ref_q[`FDN_REF_RDIV] == 12'h000) ? 12'h001 : ref_q[`FDN_REF_RDIV];

  // Counts doubled or plain reference events, so both stages may be used at once
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rcnt_q    <= 12'h000;
      pd_tick_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pd_tick_o <= 1'b0;
      if (ref_ev)
      begin
        if (rcnt_q >= rdiv_w - 12'h001)
        begin
          rcnt_q    <= 12'h000;
          pd_tick_o <= 1'b1;
        end
        else
          rcnt_q <= rcnt_q + 12'h001;
      end
    end
  end

  // ****************************************************************
  // Delta-sigma modulator
  // ****************************************************************
  wire [21:0] den_w    = den_q[21:0];
  wire [21:0] num_w    = (num_q[21:0] >= den_w) ? den_w - 22'h000001 : num_q[21:0];
  wire        fb_end   = vco_ev & (fcnt_q >= n_inst_o - 18'h00001);
  wire [1:0]  order_w  = cfg0_q[`FDN_CFG0_ORDER];
  wire [2:0]  dith_w   = (cfg0_q[`FDN_CFG0_DITHER] == 2'b00) ? 3'h0 :
                         (cfg0_q[`FDN_CFG0_DITHER] == 2'b01) ? {2'b00, lfsr_q[0]} :
                         (cfg0_q[`FDN_CFG0_DITHER] == 2'b10) ? {1'b0, lfsr_q[1:0]} : lfsr_q[2:0];
  wire [21:0] acc_w [0:2];
  wire [21:0] in_w  [0:2];
  wire [2:0]  car_w;
  wire [22:0] dsum_w   = {1'b0, acc_w[0]} + {20'h00000, dith_w};

  // Dither enters stage two, whose output is differenced, so the mean is kept
  assign in_w[0] = num_w;
  assign in_w[1] = (dsum_w < {1'b0, den_w}) ? dsum_w[21:0] : acc_w[0];
  assign in_w[2] = acc_w[1];

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_stage
      fdn_mash_acc u_acc
      (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .clr_i   (cfg0_wr),
        .step_i  (fb_end),
        .den_i   (den_w),
        .in_i    (in_w[g]),
        .acc_o   (acc_w[g]),
        .carry_o (car_w[g])
      );
    end
  endgenerate

  // Noise-cancel terms: order 1 uses c1, 2 adds c2 difference, 3 adds c3 second difference
  wire [3:0] d1  = {3'b000, car_w[0]};
  wire [3:0] d2  = {3'b000, car_w[1]} - {3'b000, c2p_q};
  wire [3:0] d3  = {3'b000, car_w[2]} - {2'b00, c3p_q, 1'b0} + {3'b000, c3pp_q};
  wire [3:0] dn  = (order_w == 2'b00) ? 4'h0 :
                   (order_w == 2'b01) ? d1 :
                   (order_w == 2'b10) ? d1 + d2 : d1 + d2 + d3;
  wire [17:0] n_next = {2'b00, cfg0_q[`FDN_CFG0_INT]} + {{14{dn[3]}}, dn};

  // History of carries, cleared with the stages so the sequence restarts
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      c2p_q    <= 1'b0;
      c3p_q    <= 1'b0;
      c3pp_q   <= 1'b0;
      lfsr_q   <= `FDN_LFSR_SEED;
      n_inst_o <= {2'b00, `FDN_RST_INT};
    end
    else if (ce_i)
    begin
      if (cfg0_wr)
      begin
        c2p_q  <= 1'b0;
        c3p_q  <= 1'b0;
        c3pp_q <= 1'b0;
        lfsr_q <= `FDN_LFSR_SEED;
      end
      else if (fb_end)
      begin
        c2p_q    <= car_w[1];
        c3p_q    <= car_w[2];
        c3pp_q   <= c3p_q;
        lfsr_q   <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        n_inst_o <= n_next;
      end
    end
  end

  // ****************************************************************
  // Feedback divider and output divider
  // ****************************************************************
  wire [5:0] ohalf_w = (ref_q[`FDN_REF_ODIV] < 6'h02) ? 6'h01 : {1'b0, ref_q[21:17]};

  // A new N is taken only at the end of a feedback divider cycle; a new output ratio applies at once
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fcnt_q    <= 18'h00000;
      fb_tick_o <= 1'b0;
      ocnt_q    <= 6'h00;
      out_clk_o <= 1'b0;
    end
    else if (ce_i)
    begin
      fb_tick_o <= fb_end;
      if (vco_ev)
        fcnt_q <= fb_end ? 18'h00000 : fcnt_q + 18'h00001;
      if (vco_ev)
      begin
        if (ocnt_q >= ohalf_w - 6'h01)
        begin
          ocnt_q    <= 6'h00;
          out_clk_o <= ~out_clk_o;
        end
        else
          ocnt_q <= ocnt_q + 6'h01;
      end
    end
  end

  // ****************************************************************
  // VCO band calibration, timed by rising reference edges
  // ****************************************************************
  wire [25:0] target_w = cal_q[`FDN_CAL_WIN] * cfg0_q[`FDN_CFG0_INT];
  wire        fast_w   = vco_cnt_gt(vcnt_q, target_w);
  wire        edge_w   = fast_w ? (osc_cap_select_code_o == 8'hFF) : (osc_cap_select_code_o == 8'h00);

  function vco_cnt_gt;
    input [25:0] a;
    input [25:0] b;
    begin
      vco_cnt_gt = (a > b);
    end
  endfunction

  // Search walks the cap code from the host's start point until the error changes sign or is zero, the code reaches an end, or the step limit is hit
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cal_st_q   <= CAL_IDLE;
      win_q      <= 10'h000;
      vcnt_q     <= 26'h0000000;
      steps_q    <= 9'h000;
      dir_q      <= 1'b0;
      dir_ok_q   <= 1'b0;
      cal_done_q <= 1'b0;
      cal_busy_o <= 1'b0;
      vco_core_o <= 2'b00;
      osc_cap_select_code_o <= `FDN_RST_CODE;
    end
    else if (ce_i)
    begin
      if (cfg0_wr)
      begin
        cal_st_q   <= CAL_MEAS;
        win_q      <= 10'h000;
        vcnt_q     <= 26'h0000000;
        steps_q    <= 9'h000;
        dir_ok_q   <= 1'b0;
        cal_done_q <= 1'b0;
        cal_busy_o <= 1'b1;
        vco_core_o <= cal_q[`FDN_CAL_CORE];
        osc_cap_select_code_o <= cal_q[`FDN_CAL_CODE];
      end
      else
      begin
        case (cal_st_q)
          CAL_IDLE: cal_busy_o <= 1'b0;
          CAL_MEAS:
          begin
            if (vco_ev)
              vcnt_q <= vcnt_q + 26'h0000001;
            // Window length counts reference edges, so a missing reference stalls here
            if (ref_rise)
            begin
              if (win_q >= cal_q[`FDN_CAL_WIN] - 10'h001)
              begin
                win_q   <= 10'h000;
                vcnt_q  <= 26'h0000000;
                steps_q <= steps_q + 9'h001;
                dir_q   <= fast_w;
                dir_ok_q <= 1'b1;
                if ((dir_ok_q & (dir_q != fast_w)) | edge_w | (steps_q >= `FDN_CAL_MAX_STEPS) |
                    (vcnt_q == target_w))
                  cal_st_q <= CAL_DONE;
                else if (fast_w)
                  osc_cap_select_code_o <= osc_cap_select_code_o + 8'h01;
                else
                  osc_cap_select_code_o <= osc_cap_select_code_o - 8'h01;
              end
              else
                win_q <= win_q + 10'h001;
            end
          end
          CAL_DONE:
          begin
            cal_busy_o <= 1'b0;
            cal_done_q <= 1'b1;
            cal_st_q   <= CAL_IDLE;
          end
          default: cal_st_q <= CAL_IDLE;
        endcase
      end
    end
  end

endmodule // fdn_core

`default_nettype wire

// file: fdn_core_assertions.sv
// Port-level checks for the fractional-N divider control block.
// Assumes full-word bus writes, so the shadow fields copy write data whole.
`default_nettype none
`include "fdn_map.vh"
module fdn_core_assertions
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        pd_tick_o,
  input wire logic        fb_tick_o,
  input wire logic [17:0] n_inst_o,
  input wire logic [1:0]  vco_core_o,
  input wire logic [7:0]  osc_cap_select_code_o,
  input wire logic        cal_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] int_q;
  logic [3:0]  mode_q;
  logic [9:0]  start_q;
  logic        settled_q;
  wire         wr_ok   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & ce_i;
  wire         cfg0_wr = wr_ok & (wb_adr_i == `FDN_ADDR_CFG0);
  // Shadow setup; settled waits one tick since the N in flight may predate a write
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      int_q     <= `FDN_RST_INT;
      mode_q    <= 4'h0;
      start_q   <= {2'b00, `FDN_RST_CODE};
      settled_q <= 1'b0;
    end
    else
    begin
      if (cfg0_wr)
      begin
        int_q     <= wb_dat_i[15:0];
        mode_q    <= wb_dat_i[19:16];
        settled_q <= 1'b0;
      end
      else if (fb_tick_o)
        settled_q <= 1'b1;
      if (wr_ok && wb_adr_i == `FDN_ADDR_CAL)
        start_q <= wb_dat_i[9:0];
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence s_cfg0;
    cfg0_wr;
  endsequence
  AST_ACK_NEXT: assert property (s_take |=> wb_ack_o)
    else $error("bus ack missing after request");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  AST_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("bus ack without request");
  AST_CAL_START: assert property (s_cfg0 |=> cal_busy_o)
    else $error("calibration not started by first register write");
  AST_CAL_FROM: assert property (s_cfg0 |=> {vco_core_o, osc_cap_select_code_o} == start_q)
    else $error("calibration not started from chosen core and code");
  AST_PD_PULSE: assert property (pd_tick_o |=> !pd_tick_o)
    else $error("phase detector tick wider than one cycle");
  AST_FB_PULSE: assert property (fb_tick_o |=> !fb_tick_o)
    else $error("feedback tick wider than one cycle");
  AST_N_HOLD: assert property ($changed(n_inst_o) |-> fb_tick_o)
    else $error("divide value changed between feedback cycles");
  AST_INT_N: assert property (fb_tick_o && settled_q && mode_q == 4'h0 |-> n_inst_o == {2'b00, int_q})
    else $error("integer mode divide value differs from integer setting");
  AST_FRAC1_N: assert property (fb_tick_o && settled_q && mode_q == 4'h1 |->
    n_inst_o == {2'b00, int_q} || n_inst_o == {2'b00, int_q} + 18'h00001)
    else $error("first order divide value out of range");
endmodule // fdn_core_assertions
bind fdn_core fdn_core_assertions i_fdn_core_assertions (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .pd_tick_o(pd_tick_o), .fb_tick_o(fb_tick_o), .n_inst_o(n_inst_o),
  .vco_core_o(vco_core_o), .osc_cap_select_code_o(osc_cap_select_code_o), .cal_busy_o(cal_busy_o));
`default_nettype wire

// file: fdn_osc_model.sv
// Free-running reference and VCO feedback sources for the divider bench.
// Assumes both are slow against the bench clock: each phase lasts several clocks.
`default_nettype none
module fdn_osc_model
#(
  parameter int REF_HALF = 5,
  parameter int VCO_HALF = 3
)
(
  input  wire logic clk_i,
  output var  logic ref_o,
  output var  logic vco_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int ref_cnt = 0;
  int vco_cnt = 0;
  initial ref_o = 1'b0;
  initial vco_o = 1'b0;
  // Reference runs from time zero, so it is alive before any first-register write
  always @(posedge clk_i)
  begin
    ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
    if (ref_cnt == REF_HALF - 1)
      ref_o <= ~ref_o;
  end
  // Fixed VCO rate; the bench does not model tuning by the cap code
  always @(posedge clk_i)
  begin
    vco_cnt <= (vco_cnt == VCO_HALF - 1) ? 0 : vco_cnt + 1;
    if (vco_cnt == VCO_HALF - 1)
      vco_o <= ~vco_o;
  end
endmodule // fdn_osc_model
`default_nettype wire

// file: test_fdn_core.sv
// Self-checking bench for the fractional-N divider control block.
// Assumes the oscillator model periods of 10 and 6 clocks for reference and VCO.
`default_nettype none
`include "fdn_map.vh"
`define FDN_CHECK(w, e, g) check_val(w, 32'(e), 32'(g))
module test_fdn_core;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int VCO_PER = 6;
  localparam logic [39:0] RST_TAB [7] = '{{8'h00, 32'h00000064}, {8'h04, 32'h00000000}, {8'h08, 32'h00000001},
    {8'h0C, 32'h00020001}, {8'h10, 32'h0064007F}, {8'h14, 32'h000007F0}, {8'h18, 32'h00000000}};
  localparam int REF_TAB [5][5] = '{'{1, 0, 2, 10, 12}, '{3, 0, 4, 30, 24}, '{0, 0, 0, 10, 12},
    '{3, 1, 38, 15, 228}, '{1, 1, 6, 5, 36}};
  localparam int MOD_TAB [7][3] = '{'{0, 0, 0}, '{1, 0, 0}, '{2, 0, 3}, '{3, 0, 3}, '{2, 1, 3}, '{3, 2, 3}, '{3, 3, 3}};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i  = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h00000000;
  logic [3:0]  bsel  = 4'hF;
  logic [31:0] rdat;
  logic        ack, pd_tick, fb_tick, out_clk, busy, ref_clk, vco_clk, out_q;
  logic [17:0] n_inst;
  logic [1:0]  core;
  logic [7:0]  code;
  int          fail_count = 0;
  int          total_checks = 0;
  always #5 clk_i = ~clk_i;
  // Last output level, for finding its rising edge
  always @(posedge clk_i) out_q <= out_clk;
  fdn_osc_model i_fdn_osc_model (.clk_i(clk_i), .ref_o(ref_clk), .vco_o(vco_clk));
  fdn_core i_fdn_core (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .reference_input_i(ref_clk), .vco_feedback_i(vco_clk), .pd_tick_o(pd_tick), .fb_tick_o(fb_tick),
    .out_clk_o(out_clk), .n_inst_o(n_inst), .vco_core_o(core), .osc_cap_select_code_o(code), .cal_busy_o(busy));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check_val(input string w, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", w, e, g);
    end
  endtask
  // Request held until ack is sampled; read data taken at that same edge
  // No local limit: only the watchdog ends a transfer that never gets its ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= bsel;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    // Ack follows the edge that takes the request, so two edges after launch
    `FDN_CHECK("bus ack latency", 2, n);
  endtask
  // Cycles to the next event: 0 detector tick, 1 feedback tick, 2 output rise
  task automatic next_ev(input int k, output int c);
    c = 0;
    do
    begin
      @(posedge clk_i);
      c++;
    end
    while (!(k == 0 ? pd_tick === 1'b1 : k == 1 ? fb_tick === 1'b1 : out_clk === 1'b1 && out_q === 1'b0) && c < 3000);
  endtask
  task automatic chk_tab(input int lo);
    logic [31:0] q;
    for (int i = lo; i < 7; i++)
    begin
      bus(1'b0, RST_TAB[i][39:32], 32'h0, q);
      `FDN_CHECK("register value", RST_TAB[i][31:0], q);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    logic [31:0] q;
    `FDN_CHECK("reset outputs", {18'h00064, 2'b00, 8'h7F, 1'b0}, {n_inst, core, code, busy});
    chk_tab(0);
    bus(1'b1, `FDN_ADDR_DEN, 32'h0, q);
    bus(1'b0, `FDN_ADDR_DEN, 32'h0, q);
    `FDN_CHECK("den zero", 32'h1, q);
    bus(1'b1, `FDN_ADDR_DEN, 32'hFFFFFFFF, q);
    bus(1'b0, `FDN_ADDR_DEN, 32'h0, q);
    `FDN_CHECK("den max", 32'h003FFFFF, q);
    // Only byte lane one may land; the other lanes keep their zeros
    bsel = 4'h2;
    bus(1'b1, `FDN_ADDR_NUM, 32'hFFFFFFFF, q);
    bsel = 4'hF;
    bus(1'b0, `FDN_ADDR_NUM, 32'h0, q);
    `FDN_CHECK("byte lane write", 32'h0000FF00, q);
    bus(1'b1, `FDN_ADDR_STAT, 32'hFFFFFFFF, q);
    bus(1'b1, 8'h18, 32'hFFFFFFFF, q);
    chk_tab(5);
  endtask
  task automatic t_ref;
    logic [31:0] q;
    int c;
    foreach (REF_TAB[i])
    begin
      bus(1'b1, `FDN_ADDR_REF, 32'(REF_TAB[i][0]) | 32'(REF_TAB[i][1]) << 12 | 32'(REF_TAB[i][2]) << 16, q);
      repeat (3) next_ev(0, c);
      `FDN_CHECK("detector interval", REF_TAB[i][3], c);
      repeat (3) next_ev(2, c);
      `FDN_CHECK("output interval", REF_TAB[i][4], c);
    end
  endtask
  // Sum of 16 divide values against 16 x (5 + 1/4), or 16 x 5 in order 0, and each period against its value
  task automatic t_mod;
    logic [31:0] q;
    int c, s, n, d;
    bus(1'b1, `FDN_ADDR_NUM, 32'h1, q);
    bus(1'b1, `FDN_ADDR_DEN, 32'h4, q);
    foreach (MOD_TAB[i])
    begin
      bus(1'b1, `FDN_ADDR_CFG0, 32'h5 | 32'(MOD_TAB[i][0]) << 16 | 32'(MOD_TAB[i][1]) << 18, q);
      repeat (2) next_ev(1, c);
      n = int'(n_inst);
      s = 0;
      repeat (16)
      begin
        next_ev(1, c);
        `FDN_CHECK("feedback interval", n * VCO_PER, c);
        n = int'(n_inst);
        s += n;
      end
      d = s - (MOD_TAB[i][0] == 0 ? 80 : 84);
      `FDN_CHECK("divide average", 1'b1, d <= MOD_TAB[i][2] && d >= -MOD_TAB[i][2]);
    end
  endtask
  task automatic t_restart;
    logic [31:0] q;
    logic [17:0] seq [8];
    int c;
    bus(1'b1, `FDN_ADDR_NUM, 32'h3, q);
    bus(1'b1, `FDN_ADDR_DEN, 32'h7, q);
    for (int p = 0; p < 2; p++)
    begin
      bus(1'b1, `FDN_ADDR_CFG0, 32'h000F0005, q);
      for (int k = 0; k < 8; k++)
      begin
        next_ev(1, c);
        if (p == 0)
          seq[k] = n_inst;
        else
          `FDN_CHECK("sequence after rewrite", seq[k], n_inst);
      end
    end
  endtask
  task automatic t_cal;
    logic [31:0] q;
    int c;
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b1, `FDN_ADDR_CAL, (i ? 32'h7F : 32'h0F) | (i ? 32'h2 : 32'h3) << 8 | 32'h4 << 16, q);
      bus(1'b1, `FDN_ADDR_CFG0, 32'h5, q);
      @(negedge clk_i);
      `FDN_CHECK("calibration start", {1'b1, i ? 10'h27F : 10'h30F}, {busy, core, code});
      c = 0;
      while (busy !== 1'b0 && c < 9000)
      begin
        @(posedge clk_i);
        c++;
      end
      bus(1'b0, `FDN_ADDR_STAT, 32'h0, q);
      `FDN_CHECK("calibration done", 2'b10, q[1:0]);
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_ref;
    t_mod;
    t_restart;
    t_cal;
    results;
  end
  // About 40,000 cycles, three times what the scenarios need
  initial
  begin
    #400000;
    fail_count++;
    results;
  end
endmodule // test_fdn_core
`default_nettype wire
